// [logic/fb_pkg.sv]
// shared constants, types and abort code decode for the fieldbus error/sync block
package fb_pkg;
    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 25_000_000;
    localparam int CLK_NS       = 1_000_000_000 / CLK_HZ;
    localparam int T_HALF_MS_NS = 500_000;
    localparam int T_1MS_NS     = 1_000_000;
    localparam int T_8MS_NS     = 8_000_000;
    localparam int T_SDO_TO_NS  = 100_000;
    localparam int HALF_MS_CYC  = T_HALF_MS_NS / CLK_NS;
    localparam int MS1_CYC      = (T_1MS_NS + CLK_NS - 1) / CLK_NS;  // least time, round up
    localparam int MS8_CYC      = T_8MS_NS / CLK_NS;                 // longest time, round down
    localparam int SDO_TO_CYC   = T_SDO_TO_NS / CLK_NS;
    localparam int DC_TOL_CYC   = 2;
    localparam int CNT_W        = 18;
    localparam int TO_W         = 12;

    // ------------------------------------------------------------------
    // link encodings
    // ------------------------------------------------------------------
    localparam logic [2:0]  CCS_MAX     = 3'h4;
    localparam logic [15:0] EMCY_ALARM  = 16'hff00;
    localparam logic [15:0] EMCY_ESM    = 16'ha000;
    localparam logic [7:0]  ESM_CHANNEL = 8'h02;
    localparam logic [7:0]  ESM_DIAG    = 8'h0a;
    localparam logic [2:0]  PROF_TOP    = 3'h3;  // index[15:13] of the profile area

    typedef enum logic [1:0] {
        MODE_FREE = 2'h0,
        MODE_SM2  = 2'h1,
        MODE_DC   = 2'h2
    } sync_mode_t;

    typedef enum logic [4:0] {
        C_OK, C_ACC_UNSUP, C_WRITE_ONLY, C_READ_ONLY, C_NO_OBJ, C_NO_SUB,
        C_NOT_MAPPABLE, C_MAP_OVER, C_LEN, C_LEN_LONG, C_LEN_SHORT, C_RANGE,
        C_TOO_BIG, C_TOO_SMALL, C_MAX_LT_MIN, C_GENERAL, C_STORE, C_STORE_LOCAL,
        C_STORE_STATE, C_HW, C_PARAM_INCOMPAT, C_INT_INCOMPAT, C_NO_DICT,
        C_MEM_RANGE, C_TOGGLE, C_TIMEOUT, C_BAD_CCS
    } sdo_cause_t;

    // abort value for each failure cause
    function automatic logic [31:0] abort_code(input sdo_cause_t c);
        logic [31:0] v;
        v = 32'h0800_0000;
        case (c)
            C_TOGGLE:         v = 32'h0503_0000;
            C_TIMEOUT:        v = 32'h0504_0000;
            C_BAD_CCS:        v = 32'h0504_0001;
            C_MEM_RANGE:      v = 32'h0504_0005;
            C_ACC_UNSUP:      v = 32'h0601_0000;
            C_WRITE_ONLY:     v = 32'h0601_0001;
            C_READ_ONLY:      v = 32'h0601_0002;
            C_NO_OBJ:         v = 32'h0602_0000;
            C_NOT_MAPPABLE:   v = 32'h0604_0041;
            C_MAP_OVER:       v = 32'h0604_0042;
            C_PARAM_INCOMPAT: v = 32'h0604_0043;
            C_INT_INCOMPAT:   v = 32'h0604_0047;
            C_HW:             v = 32'h0606_0000;
            C_LEN:            v = 32'h0607_0010;
            C_LEN_LONG:       v = 32'h0607_0012;
            C_LEN_SHORT:      v = 32'h0607_0013;
            C_NO_SUB:         v = 32'h0609_0011;
            C_RANGE:          v = 32'h0609_0030;
            C_TOO_BIG:        v = 32'h0609_0031;
            C_TOO_SMALL:      v = 32'h0609_0032;
            C_MAX_LT_MIN:     v = 32'h0609_0036;
            C_STORE:          v = 32'h0800_0020;
            C_STORE_LOCAL:    v = 32'h0800_0021;
            C_STORE_STATE:    v = 32'h0800_0022;
            C_NO_DICT:        v = 32'h0800_0023;
            default:          v = 32'h0800_0000;
        endcase
        return v;
    endfunction
endpackage

// [logic/fb_link_if.sv]
// link between the fieldbus master end and the drive end
`timescale 1ns/1ns
interface fb_link_if;
    logic        req;        // service request strobe
    logic [2:0]  ccs;        // command specifier
    logic        seg;        // segment request, toggle checked
    logic        toggle;     // toggle bit of a segment
    logic [15:0] index;
    logic [7:0]  sub;
    logic        rsp;        // answer strobe
    logic        abort;      // answer is an abort
    logic [31:0] code;       // abort value
    logic        frame;      // output process-data frame received
    logic        sync0;      // distributed-clock pulse
    logic        emcy_valid;
    logic [63:0] emcy_data;  // byte 0 in bits 7:0
    logic        emcy_ready;

    modport dev (input req, ccs, seg, toggle, index, sub, frame, sync0, emcy_ready,
                 output rsp, abort, code, emcy_valid, emcy_data);
    modport mst (output req, ccs, seg, toggle, index, sub, frame, sync0, emcy_ready,
                 input rsp, abort, code, emcy_valid, emcy_data);
endinterface

// [logic/fb_drive_end.sv]
// drive end: service abort selection, emergency framing and sync timing
`timescale 1ns/1ns
module fb_drive_end
    import fb_pkg::*;
#(
    parameter int P_HALF = HALF_MS_CYC,
    parameter int P_MS1  = MS1_CYC,
    parameter int P_MS8  = MS8_CYC,
    parameter int P_TO   = SDO_TO_CYC
) (
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    fb_link_if.dev          link,
    input  wire sync_mode_t i_mode,
    output logic            o_app_tick,
    output logic            o_cycle_short,
    output logic            o_dc_bad,
    output logic            o_sdo_req,
    output logic [2:0]      o_sdo_ccs,
    output logic [15:0]     o_sdo_index,
    output logic [7:0]      o_sdo_sub,
    output logic [2:0]      o_sdo_axis,
    input  wire logic       i_sdo_done,
    input  wire sdo_cause_t i_sdo_cause,
    output logic            o_sdo_commit,
    input  wire logic       i_alarm,
    input  wire logic [7:0] i_alarm_axis,
    input  wire logic [7:0] i_alarm_code,
    input  wire logic [7:0] i_err_reg,
    input  wire logic       i_alarm_clear,
    input  wire logic       i_safeop_req,
    input  wire logic       i_map_unmappable,
    input  wire logic       i_map_wrong_dir,
    input  wire logic       i_map_other_axis,
    output logic            o_safeop_ok,
    output logic            o_safeop_fail
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_WAIT = 2'b10
    } sdo_st_t;

    typedef struct packed {
        sdo_st_t          st;
        logic             exp_tog;
        logic [TO_W-1:0]  to_cnt;
        logic             rsp;
        logic             abort;
        logic [31:0]      code;
        logic             sreq;
        logic [2:0]       ccs;
        logic [15:0]      idx;
        logic [7:0]       sub;
        logic [2:0]       axis;
        logic             commit;
        logic [CNT_W-1:0] gap;
        logic [CNT_W-1:0] frun;
        logic             tick;
        logic             short;
        logic             dc_bad;
        logic             evalid;
        logic [63:0]      edata;
        logic             pend_al;
        logic             pend_esm;
        logic [7:0]       al_axis;
        logic [7:0]       al_code;
        logic [7:0]       al_reg;
        logic             al_sent;
        logic             sok;
        logic             sfail;
    } dev_st_t;

    localparam logic [CNT_W-1:0] GAP_SAT = '1;

    dev_st_t r;
    dev_st_t next_r;
    logic [CNT_W-1:0] ivl;
    logic             ev;
    logic             dc_ok;
    logic             al_new;
    logic             esm_fail;

    // ------------------------------------------------------------------
    // cycle measurement helpers
    // ------------------------------------------------------------------
    // interval ending at this event, events chosen by mode
    assign ivl = r.gap + CNT_W'(1);
    assign ev  = (i_mode == MODE_DC) ? link.sync0 : link.frame;
    assign dc_ok = ((ivl >= CNT_W'(P_HALF - DC_TOL_CYC)) && (ivl <= CNT_W'(P_HALF + DC_TOL_CYC)))
                || ((ivl >= CNT_W'(P_MS1 - DC_TOL_CYC)) && (ivl <= CNT_W'(P_MS8 + DC_TOL_CYC)));
    // an alarm equal to the last one sent is not reported again until i_alarm_clear
    assign al_new = i_alarm && !(r.al_sent && (r.al_axis == i_alarm_axis)
                              && (r.al_code == i_alarm_code));
    assign esm_fail = ((i_mode == MODE_DC) && r.dc_bad) || i_map_unmappable
                    || i_map_wrong_dir || i_map_other_axis;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r        = r;
        next_r.rsp    = 1'b0;
        next_r.sreq   = 1'b0;
        next_r.commit = 1'b0;
        next_r.tick   = 1'b0;
        next_r.sok    = 1'b0;
        next_r.sfail  = 1'b0;

        // service exchange, taken only in S_IDLE; a request during S_WAIT is ignored
        unique case (r.st)
            S_IDLE: begin
                if (link.req) begin
                    next_r.ccs = link.ccs;
                    next_r.idx = link.index;
                    next_r.sub = link.sub;
                    // profile index folded back to axis 1, axis number kept
                    if (link.index[15:13] == PROF_TOP) begin
                        next_r.axis = {1'b0, link.index[12:11]} + 3'h1;
                        next_r.idx  = {link.index[15:13], 2'b00, link.index[10:0]};
                    end else begin
                        next_r.axis = 3'h0;
                    end
                    if (link.ccs > CCS_MAX) begin
                        next_r.rsp   = 1'b1;
                        next_r.abort = 1'b1;
                        next_r.code  = abort_code(C_BAD_CCS);
                    end else if (link.seg && (link.toggle != r.exp_tog)) begin
                        next_r.rsp   = 1'b1;
                        next_r.abort = 1'b1;
                        next_r.code  = abort_code(C_TOGGLE);
                    end else begin
                        next_r.st     = S_WAIT;
                        next_r.sreq   = 1'b1;
                        next_r.to_cnt = '0;
                    end
                end
            end
            S_WAIT: begin
                next_r.to_cnt = r.to_cnt + TO_W'(1);
                if (i_sdo_done) begin
                    next_r.st  = S_IDLE;
                    next_r.rsp = 1'b1;
                    if (i_sdo_cause == C_OK) begin
                        next_r.abort   = 1'b0;
                        next_r.code    = 32'h0;
                        next_r.commit  = 1'b1;
                        next_r.exp_tog = link.seg ? ~r.exp_tog : 1'b0;
                    end else begin
                        // object stays as it was, one abort word returned
                        next_r.abort = 1'b1;
                        next_r.code  = abort_code(i_sdo_cause);
                    end
                end else if (r.to_cnt == TO_W'(P_TO - 1)) begin
                    next_r.st    = S_IDLE;
                    next_r.rsp   = 1'b1;
                    next_r.abort = 1'b1;
                    next_r.code  = abort_code(C_TIMEOUT);
                end
            end
        endcase

        // interval since the last event, saturating
        if (r.gap != GAP_SAT) begin
            next_r.gap = r.gap + CNT_W'(1);
        end
        if (ev) begin
            next_r.gap = '0;
            if (r.gap != GAP_SAT) begin
                if (i_mode == MODE_DC) begin
                    next_r.dc_bad = !dc_ok;
                end else begin
                    next_r.short = (ivl < CNT_W'(P_MS1));
                end
            end
        end

        // application tick: own timer, frame event or sync pulse
        next_r.frun = (r.frun == CNT_W'(P_MS1 - 1)) ? '0 : r.frun + CNT_W'(1);
        unique case (i_mode)
            MODE_FREE: next_r.tick = (r.frun == CNT_W'(P_MS1 - 1));
            MODE_SM2:  next_r.tick = link.frame;
            MODE_DC:   next_r.tick = link.sync0;
            default:   next_r.tick = 1'b0;
        endcase

        // emergency path: accepted message leaves, next pending one loads
        if (r.evalid && link.emcy_ready) begin
            next_r.evalid = 1'b0;
        end
        if (!r.evalid && r.pend_al) begin
            next_r.evalid  = 1'b1;
            next_r.pend_al = 1'b0;
            next_r.edata   = {24'h0, r.al_code, r.al_axis, r.al_reg,
                              EMCY_ALARM[15:8], EMCY_ALARM[7:0]};
        end else if (!r.evalid && r.pend_esm) begin
            next_r.evalid   = 1'b1;
            next_r.pend_esm = 1'b0;
            next_r.edata    = {32'h0, ESM_DIAG, ESM_CHANNEL,
                               EMCY_ESM[15:8], EMCY_ESM[7:0]};
        end

        // error events; a new event wins over a clear in the same cycle
        if (i_alarm_clear) begin
            next_r.al_sent = 1'b0;
        end
        if (al_new) begin
            next_r.pend_al = 1'b1;
            next_r.al_sent = 1'b1;
            next_r.al_axis = i_alarm_axis;
            next_r.al_code = i_alarm_code;
            next_r.al_reg  = i_err_reg;
        end
        if (i_safeop_req) begin
            next_r.sok   = !esm_fail;
            next_r.sfail = esm_fail;
            if (esm_fail) begin
                next_r.pend_esm = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            r     <= '0;
            r.st  <= S_IDLE;
            r.gap <= GAP_SAT;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.rsp        = r.rsp;
    assign link.abort      = r.abort;
    assign link.code       = r.code;
    assign link.emcy_valid = r.evalid;
    assign link.emcy_data  = r.edata;
    assign o_app_tick      = r.tick;
    assign o_cycle_short   = r.short;
    assign o_dc_bad        = r.dc_bad;
    assign o_sdo_req       = r.sreq;
    assign o_sdo_ccs       = r.ccs;
    assign o_sdo_index     = r.idx;
    assign o_sdo_sub       = r.sub;
    assign o_sdo_axis      = r.axis;
    assign o_sdo_commit    = r.commit;
    assign o_safeop_ok     = r.sok;
    assign o_safeop_fail   = r.sfail;
endmodule

// [logic/fb_master_end.sv]
// master end: issues service requests, frame and sync pulses, takes emergencies
`timescale 1ns/1ns
module fb_master_end
    import fb_pkg::*;
#(
    parameter int P_CYCLE = MS1_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    fb_link_if.mst           link,
    input  wire logic        i_sdo_start,
    input  wire logic [2:0]  i_ccs,
    input  wire logic        i_seg,
    input  wire logic        i_toggle,
    input  wire logic [15:0] i_index,
    input  wire logic [7:0]  i_sub,
    output logic             o_sdo_busy,
    output logic             o_sdo_done,
    output logic             o_sdo_abort,
    output logic [31:0]      o_sdo_code,
    input  wire logic        i_run,
    input  wire logic        i_dc_en,
    input  wire logic        i_emcy_hold,
    output logic             o_emcy_new,
    output logic [15:0]      o_emcy_code,
    output logic [7:0]       o_emcy_reg,
    output logic [39:0]      o_emcy_info
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             busy;
        logic             req;
        logic [2:0]       ccs;
        logic             seg;
        logic             toggle;
        logic [15:0]      idx;
        logic [7:0]       sub;
        logic             done;
        logic             abort;
        logic [31:0]      code;
        logic [CNT_W-1:0] cyc;
        logic             frame;
        logic             sync0;
        logic             enew;
        logic [63:0]      edata;
    } mst_st_t;

    mst_st_t r;
    mst_st_t next_r;
    logic    take;

    assign take = link.emcy_valid && !i_emcy_hold;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r       = r;
        next_r.req   = 1'b0;
        next_r.done  = 1'b0;
        next_r.frame = 1'b0;
        next_r.sync0 = 1'b0;
        next_r.enew  = 1'b0;
        // one outstanding service request, a start while busy is ignored
        if (!r.busy && i_sdo_start) begin
            next_r.busy   = 1'b1;
            next_r.req    = 1'b1;
            next_r.ccs    = i_ccs;
            next_r.seg    = i_seg;
            next_r.toggle = i_toggle;
            next_r.idx    = i_index;
            next_r.sub    = i_sub;
        end
        if (r.busy && link.rsp) begin
            next_r.busy  = 1'b0;
            next_r.done  = 1'b1;
            next_r.abort = link.abort;
            next_r.code  = link.code;
        end
        // communication cycle: frame each period, sync pulse in dc mode
        if (!i_run) begin
            next_r.cyc = '0;
        end else if (r.cyc == CNT_W'(P_CYCLE - 1)) begin
            next_r.cyc   = '0;
            next_r.frame = 1'b1;
            next_r.sync0 = i_dc_en;
        end else begin
            next_r.cyc = r.cyc + CNT_W'(1);
        end
        if (take) begin
            next_r.enew  = 1'b1;
            next_r.edata = link.emcy_data;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.req        = r.req;
    assign link.ccs        = r.ccs;
    assign link.seg        = r.seg;
    assign link.toggle     = r.toggle;
    assign link.index      = r.idx;
    assign link.sub        = r.sub;
    assign link.frame      = r.frame;
    assign link.sync0      = r.sync0;
    assign link.emcy_ready = !i_emcy_hold;
    assign o_sdo_busy      = r.busy;
    assign o_sdo_done      = r.done;
    assign o_sdo_abort     = r.abort;
    assign o_sdo_code      = r.code;
    assign o_emcy_new      = r.enew;
    assign o_emcy_code     = {r.edata[15:8], r.edata[7:0]};
    assign o_emcy_reg      = r.edata[23:16];
    assign o_emcy_info     = r.edata[63:24];
endmodule

// [tb/fb_link_chk.sv]
// assertions on the link between the master end and the drive end
`timescale 1ns/1ns
module fb_link_chk (
    input wire logic        i_mclk,
    input wire logic        i_srst,
    input wire logic        req,
    input wire logic [2:0]  ccs,
    input wire logic        rsp,
    input wire logic        abort,
    input wire logic [31:0] code,
    input wire logic        emcy_valid,
    input wire logic [63:0] emcy_data,
    input wire logic        emcy_ready
);
    // ----------------------------------------
    // service and emergency checks
    // ----------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);
    chk_bad_spec: assert property (req && ccs > 3'h4 |=>
        rsp && abort && code == 32'h0504_0001) else $error("bad specifier not refused");
    chk_answer_due: assert property (req |-> ##[1:24] rsp)
        else $error("service answer missing");
    chk_one_answer: assert property (rsp |=> !rsp)
        else $error("answer repeated");
    chk_emcy_hold: assert property (emcy_valid && !emcy_ready |=>
        emcy_valid && $stable(emcy_data)) else $error("emergency lost while stalled");
    chk_emcy_once: assert property (emcy_valid && emcy_ready |=> !emcy_valid)
        else $error("emergency sent twice");
    chk_emcy_kind: assert property (emcy_valid |->
        emcy_data[15:0] inside {16'hff00, 16'ha000}) else $error("bad emergency code");
    chk_alarm_pad: assert property (emcy_valid && emcy_data[15:0] == 16'hff00 |->
        emcy_data[63:40] == 24'h0) else $error("alarm tail not zero");
    chk_esm_body: assert property (emcy_valid && emcy_data[15:0] == 16'ha000 |->
        emcy_data[63:16] == 48'h0a02) else $error("transition message body wrong");
endmodule

// [tb/fb_link_bench.sv]
// self-checking bench joining the master end and the drive end
`timescale 1ns/1ns
module fb_link_bench;
    import fb_pkg::*;
    logic        i_mclk, i_srst, start, seg, tgl, run, done, alarm, clr, sreq, ans;
    logic [2:0]  ccs, mf, axe;
    logic [15:0] idx, idxe;
    logic [7:0]  sub, ax, ac, er;
    sdo_cause_t  cause;
    sync_mode_t  mode;
    logic        busy, sdone, sab, enew, tick, cshort, dcbad, oreq, sok, sfail;
    logic        hold, com, com_d;
    logic [31:0] scode;
    logic [15:0] ecode, oidx;
    logic [7:0]  ereg, osub;
    logic [39:0] einfo;
    logic [2:0]  oax, occs;
    logic [32:0] sexp;
    logic [32:0] sq[$];
    logic [63:0] eq[$];
    logic [31:0] seed = 32'h2d;
    int          fails = 0, n_tests = 0, nt = 0;
    localparam logic [31:0] CODES [27] = '{0, 32'h06010000, 32'h06010001, 32'h06010002,
        32'h06020000, 32'h06090011, 32'h06040041, 32'h06040042, 32'h06070010, 32'h06070012,
        32'h06070013, 32'h06090030, 32'h06090031, 32'h06090032, 32'h06090036, 32'h08000000,
        32'h08000020, 32'h08000021, 32'h08000022, 32'h06060000, 32'h06040043, 32'h06040047,
        32'h08000023, 32'h05040005, 32'h05030000, 32'h05040000, 32'h05040001};
    fb_link_if link();
    fb_master_end #(.P_CYCLE(50)) fb_master_end_inst (.i_mclk(i_mclk), .i_srst(i_srst),
        .link(link), .i_sdo_start(start), .i_ccs(ccs), .i_seg(seg), .i_toggle(tgl),
        .i_index(idx), .i_sub(sub), .o_sdo_busy(busy), .o_sdo_done(sdone), .o_sdo_abort(sab),
        .o_sdo_code(scode), .i_run(run), .i_dc_en(run), .i_emcy_hold(hold),
        .o_emcy_new(enew), .o_emcy_code(ecode), .o_emcy_reg(ereg), .o_emcy_info(einfo));
    fb_drive_end #(.P_HALF(20), .P_MS1(50), .P_MS8(200), .P_TO(20)) fb_drive_end_inst (
        .i_mclk(i_mclk), .i_srst(i_srst), .link(link), .i_mode(mode), .o_app_tick(tick),
        .o_cycle_short(cshort), .o_dc_bad(dcbad), .o_sdo_req(oreq), .o_sdo_ccs(occs),
        .o_sdo_index(oidx), .o_sdo_sub(osub), .o_sdo_axis(oax), .i_sdo_done(done),
        .i_sdo_cause(cause), .o_sdo_commit(com), .i_alarm(alarm), .i_alarm_axis(ax),
        .i_alarm_code(ac), .i_err_reg(er), .i_alarm_clear(clr), .i_safeop_req(sreq),
        .i_map_unmappable(mf[0]), .i_map_wrong_dir(mf[1]), .i_map_other_axis(mf[2]),
        .o_safeop_ok(sok), .o_safeop_fail(sfail));
    fb_link_chk fb_link_chk_inst (.i_mclk(i_mclk), .i_srst(i_srst), .req(link.req),
        .ccs(link.ccs), .rsp(link.rsp), .abort(link.abort), .code(link.code),
        .emcy_valid(link.emcy_valid), .emcy_data(link.emcy_data), .emcy_ready(link.emcy_ready));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic sdo(input logic [2:0] c, input logic s, input logic t, input logic [32:0] e);
        sq.push_back(e);
        ccs = c;
        seg = s;
        tgl = t;
        idx = 16'(rnd());
        sub = 8'(rnd());
        axe = (idx[15:13] == 3'h3) ? {1'b0, idx[12:11]} + 3'h1 : 3'h0;
        idxe = (axe != 3'h0) ? {5'h0c, idx[10:0]} : idx;
        start = 1;
        cyc(1);
        start = 0;
        chk(busy, 1'b1, "busy");
        for (int k = 0; k < 40 && sdone !== 1'b1; k++) cyc(1);
    endtask
    task automatic alm(input bit fresh, input bit push);
        if (fresh) {ax, ac, er} = 24'(rnd());
        if (push) eq.push_back({24'h0, ac, ax, er, 16'hff00});
        alarm = 1;
        cyc(1);
        alarm = 0;
        cyc(12);
    endtask
    // ----------------------------------------
    // drive user answer and result monitor
    // ----------------------------------------
    always @(posedge i_mclk) begin
        done <= #1 (oreq === 1'b1) && ans;
        if (oreq === 1'b1) chk({occs, osub, oax, oidx}, {ccs, sub, axe, idxe}, "req");
        if (tick === 1'b1) nt++;
        if (sdone === 1'b1) begin
            sexp = sq.pop_front();
            chk(sab ? {sab, scode} : 33'h0, sexp, "abort");
            chk(com_d, !sexp[32], "commit");
        end
        com_d = com;
        if (enew === 1'b1) chk({einfo, ereg, ecode}, eq.pop_front(), "emergency");
    end
    initial begin
        i_mclk = 0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        #400000;
        fails++;
        close_out();
    end
    initial begin
        {start, seg, tgl, run, hold, alarm, clr, sreq, ccs, mf, idx, sub, ax, ac, er} = '0;
        cause = C_OK;
        mode = MODE_FREE;
        ans = 1;
        i_srst = 1;
        cyc(5);
        i_srst = 0;
        run = 1;
        // every cause code, service alongside the running cycle
        for (int i = 0; i < 27; i++) begin
            cause = sdo_cause_t'(i);
            sdo(3'(rnd() % 5), 0, 0, {i != 0, CODES[i]});
        end
        // toggle, bad specifier and timeout
        cause = C_OK;
        sdo(3'h1, 0, 0, 33'h0);
        sdo(3'h1, 1, 0, 33'h0);
        sdo(3'h1, 1, 0, {1'b1, 32'h0503_0000});
        sdo(3'h1, 1, 1, 33'h0);
        sdo(3'h5 + 3'(rnd() % 3), 0, 0, {1'b1, 32'h0504_0001});
        ans = 0;
        sdo(3'h2, 0, 0, {1'b1, 32'h0504_0000});
        ans = 1;
        $display("service tests done");
        // alarms: repeat dropped until cleared
        alm(1, 1);
        alm(0, 0);
        clr = 1;
        cyc(1);
        clr = 0;
        hold = 1;
        alm(0, 1);
        hold = 0;
        cyc(4);
        $display("alarm tests done");
        // tick rate per mode, then transition checks in distributed-clock mode
        for (int m = 0; m < 3; m++) begin
            mode = sync_mode_t'(m);
            cyc(100);
            nt = 0;
            cyc(200);
            chk(nt, 4, "ticks");
            chk({cshort, dcbad}, 2'b00, "cycle flags");
        end
        // a stalled cycle in distributed-clock mode fails the transition
        run = 0;
        cyc(200);
        run = 1;
        cyc(60);
        chk(dcbad, 1'b1, "long sync cycle");
        eq.push_back({32'h0, 8'h0a, 8'h02, 16'ha000});
        sreq = 1;
        cyc(1);
        sreq = 0;
        chk({sok, sfail}, 2'b01, "stalled transition");
        cyc(60);
        for (int k = 0; k < 4; k++) begin
            mf = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
            if (k != 0) eq.push_back({32'h0, 8'h0a, 8'h02, 16'ha000});
            sreq = 1;
            cyc(1);
            sreq = 0;
            chk({sok, sfail}, (k == 0) ? 2'b10 : 2'b01, "transition");
            cyc(12);
        end
        chk(sq.size() + eq.size(), 0, "pending");
        $display("sync tests done");
        close_out();
    end
endmodule
